// file: logic/rscps_pkg.sv
// Package: register map, field layout and strap mapping for the strap capture block
// Assumes a 40 MHz sys_clk and an APB slave with 32-bit data
package rscps_pkg;
	localparam int unsigned PIN_W          = 29;
	localparam int unsigned SCAN_W         = 64;
	// Register byte offsets
	localparam logic [7:0]  OFS_MEM_CFG    = 8'h00;
	localparam logic [7:0]  OFS_SYS_CFG    = 8'h04;
	localparam logic [7:0]  OFS_MEM_TIM    = 8'h08;
	localparam logic [7:0]  OFS_PORT_SEL   = 8'h0c;
	localparam logic [7:0]  OFS_STATUS     = 8'h10;
	// Strap bit ranges per register (pin index of bit 0)
	localparam int unsigned MEM_CFG_LSB    = 0;
	localparam int unsigned SYS_CFG_LSB    = 8;
	localparam int unsigned MEM_TIM_LSB    = 16;
	localparam int unsigned PORT_SEL_LSB   = 24;
	localparam int unsigned PORT_SEL_W     = 5;
	// Memory config fields
	localparam int unsigned PAGE_LSB       = 2;
	localparam int unsigned SIZE_LSB       = 5;
	localparam int unsigned SCAN_BIT       = 1;
	localparam int unsigned SCAN_PIN       = 9;
	localparam logic [1:0]  PAGE_EDO1      = 2'h0;
	localparam logic [1:0]  PAGE_EDO2      = 2'h2;
	localparam logic [1:0]  PAGE_FPM       = 2'h3;
	localparam logic [2:0]  SIZE_4M        = 3'h0;
	localparam logic [2:0]  SIZE_2M        = 3'h4;
	localparam logic [2:0]  SIZE_1M        = 3'h6;
	localparam logic [7:0]  REG_RST        = 8'hff;
	localparam logic [31:0] DEAD_DATA      = 32'h0000_0000;

	typedef enum logic [2:0] {
		RSCPS_ST_RESET = 3'b001,
		RSCPS_ST_RUN   = 3'b010,
		RSCPS_ST_SCAN  = 3'b100
	} rscps_state_t;
endpackage

// file: logic/rscps_cfg_if.sv
// Interface: captured/stored configuration between register file and top
// Assumes one clock domain shared by both sides
`timescale 1ns/1ps
interface rscps_cfg_if;
	logic                     capture;
	logic [rscps_pkg::PIN_W-1:0] strap_bits;
	logic [31:0]              flat_cfg;
	logic                     wr_en;
	logic [7:0]               wr_addr;
	logic [7:0]               wr_data;
	modport regs (input capture, input strap_bits, input wr_en, input wr_addr, input wr_data,
		output flat_cfg);
	modport ctrl (output capture, output strap_bits, output wr_en, output wr_addr,
		output wr_data, input flat_cfg);
endinterface

// file: logic/rscps_strap_regs.sv
// Strap registers: four byte-wide configuration registers loaded at reset release
// Assumes capture pulses once in the first cycle after reset release
`timescale 1ns/1ps
module rscps_strap_regs (
	input  wire logic      sys_clk,
	input  wire logic      arst_n,
	rscps_cfg_if.regs      cfg
);
	typedef struct packed {
		logic [7:0] mem_cfg;
		logic [7:0] sys_cfg;
		logic [7:0] mem_tim;
		logic [7:0] port_sel;
	} rscps_regs_t;

	rscps_regs_t regs_ff;
	rscps_regs_t nxt_regs;

	// Capture wins over writes; after that plain storage, no inversion
	always_comb begin
		nxt_regs = regs_ff;
		if (cfg.capture) begin
			nxt_regs.mem_cfg  = ~cfg.strap_bits[rscps_pkg::MEM_CFG_LSB +: 8];
			nxt_regs.sys_cfg  = ~cfg.strap_bits[rscps_pkg::SYS_CFG_LSB +: 8];
			nxt_regs.mem_tim  = ~cfg.strap_bits[rscps_pkg::MEM_TIM_LSB +: 8];
			nxt_regs.port_sel = {3'h7,
				~cfg.strap_bits[rscps_pkg::PORT_SEL_LSB +: rscps_pkg::PORT_SEL_W]};
		end else if (cfg.wr_en) begin
			case (cfg.wr_addr)
				rscps_pkg::OFS_MEM_CFG:  nxt_regs.mem_cfg  = cfg.wr_data;
				rscps_pkg::OFS_SYS_CFG:  nxt_regs.sys_cfg  = cfg.wr_data;
				rscps_pkg::OFS_MEM_TIM:  nxt_regs.mem_tim  = cfg.wr_data;
				rscps_pkg::OFS_PORT_SEL: nxt_regs.port_sel = cfg.wr_data;
				default:                 nxt_regs = regs_ff;
			endcase
		end
	end

	// Power-on defaults are all ones, matching an unstrapped board
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			regs_ff <= {4{rscps_pkg::REG_RST}};
		end else begin
			regs_ff <= nxt_regs;
		end
	end

	assign cfg.flat_cfg = regs_ff;
endmodule

// file: logic/rscps_top.sv
// Top: strap capture at reset release, APB register access and pin scan mode
// Assumes pins synchronous to sys_clk; pad ring combines pull and enables
`timescale 1ns/1ps
module rscps_top (
	input  wire logic                        sys_clk,
	input  wire logic                        arst_n,
	input  wire logic                        psel,
	input  wire logic                        penable,
	input  wire logic                        pwrite,
	input  wire logic [7:0]                  paddr,
	input  wire logic [31:0]                 pwdata,
	output logic      [31:0]                 prdata,
	output logic                             pready,
	output logic                             pslverr,
	input  wire logic [rscps_pkg::PIN_W-1:0] pixel_data_pins_in,
	output logic      [rscps_pkg::PIN_W-1:0] pixel_data_pins_out,
	output logic      [rscps_pkg::PIN_W-1:0] pixel_data_pins_oe,
	output logic      [rscps_pkg::PIN_W-1:0] pixel_data_pins_pulldown,
	output logic                             mem_oe_n_out,
	output logic                             mem_oe_n_oe,
	input  wire logic [rscps_pkg::SCAN_W-1:0] scan_pins_in,
	output logic                             serial_port_clock_pin_out,
	output logic                             serial_port_clock_pin_oe,
	input  wire logic                        serial_port_clock_func,
	output logic                             scan_mode,
	output logic      [1:0]                  mem_page_mode,
	output logic                             mem_page_reserved,
	output logic      [2:0]                  mem_size_mb,
	output logic                             mem_size_reserved
);
	typedef struct packed {
		rscps_pkg::rscps_state_t     state;
		logic                        scan_out;
		logic [31:0]                 rdata;
		logic                        err;
	} rscps_top_st_t;

	rscps_top_st_t st_ff;
	rscps_top_st_t nxt_st;
	rscps_cfg_if   cfg_bus ();
	logic [6:0]    low_now;
	logic          bus_acc;
	logic          hit;
	logic [31:0]   rd_mux;
	logic [7:0]    mem_cfg_q;

	// Counts inputs held low; used for the scan parity output
	function automatic logic [6:0] count_low(input logic [rscps_pkg::SCAN_W-1:0] v);
		logic [6:0] n;
		n = 7'h00;
		for (int i = 0; i < rscps_pkg::SCAN_W; i++) begin
			n = n + {6'h00, ~v[i]};
		end
		return n;
	endfunction

	// Scan inputs exclude analog, crystal, reset, supply pins by construction
	assign low_now = count_low(scan_pins_in);
	assign bus_acc = psel && penable;
	assign hit     = (paddr == rscps_pkg::OFS_MEM_CFG) || (paddr == rscps_pkg::OFS_SYS_CFG) ||
		(paddr == rscps_pkg::OFS_MEM_TIM) || (paddr == rscps_pkg::OFS_PORT_SEL) ||
		(paddr == rscps_pkg::OFS_STATUS);
	assign mem_cfg_q = cfg_bus.flat_cfg[31:24];

	// Read mux; status shows the scan state
	always_comb begin
		case (paddr)
			rscps_pkg::OFS_MEM_CFG:  rd_mux = {24'h000000, cfg_bus.flat_cfg[31:24]};
			rscps_pkg::OFS_SYS_CFG:  rd_mux = {24'h000000, cfg_bus.flat_cfg[23:16]};
			rscps_pkg::OFS_MEM_TIM:  rd_mux = {24'h000000, cfg_bus.flat_cfg[15:8]};
			rscps_pkg::OFS_PORT_SEL: rd_mux = {24'h000000, cfg_bus.flat_cfg[7:0]};
			rscps_pkg::OFS_STATUS:   rd_mux = {30'h00000000, st_ff.scan_out,
				st_ff.state == rscps_pkg::RSCPS_ST_SCAN};
			default:                 rd_mux = rscps_pkg::DEAD_DATA;
		endcase
	end

	// Next state: capture on first cycle out of reset, then run or scan
	always_comb begin
		nxt_st = st_ff;
		case (st_ff.state)
			rscps_pkg::RSCPS_ST_RESET: begin
				// Pin high means inverted bit 0, which selects the scan
				if (pixel_data_pins_in[rscps_pkg::SCAN_PIN]) begin
					nxt_st.state = rscps_pkg::RSCPS_ST_SCAN;
				end else begin
					nxt_st.state = rscps_pkg::RSCPS_ST_RUN;
				end
			end
			rscps_pkg::RSCPS_ST_RUN: begin
				nxt_st.state = rscps_pkg::RSCPS_ST_RUN;
			end
			rscps_pkg::RSCPS_ST_SCAN: begin
				// Parity of low inputs toggles once per newly lowered pin
				nxt_st.scan_out = low_now[0];
			end
			default: nxt_st.state = rscps_pkg::RSCPS_ST_RESET;
		endcase
		nxt_st.rdata = st_ff.rdata;
		nxt_st.err   = 1'b0;
		if (psel && !penable) begin
			nxt_st.rdata = rd_mux;
			nxt_st.err   = !hit;
		end
	end

	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			st_ff <= '{state: rscps_pkg::RSCPS_ST_RESET, scan_out: 1'b0,
				rdata: 32'h00000000, err: 1'b0};
		end else begin
			st_ff <= nxt_st;
		end
	end

	// Capture uses the first post-release sample of the pins
	assign cfg_bus.capture    = (st_ff.state == rscps_pkg::RSCPS_ST_RESET);
	assign cfg_bus.strap_bits = pixel_data_pins_in;
	assign cfg_bus.wr_en      = bus_acc && pwrite && hit && !cfg_bus.capture;
	assign cfg_bus.wr_addr    = paddr;
	assign cfg_bus.wr_data    = pwdata[7:0];

	rscps_strap_regs u_regs (
		.sys_clk (sys_clk),
		.arst_n  (arst_n),
		.cfg     (cfg_bus.regs)
	);

	// One wait-free access phase: answer in the access cycle
	assign pready  = 1'b1;
	assign prdata  = st_ff.rdata;
	assign pslverr = bus_acc && st_ff.err;

	// Pulls active in reset and in the capture cycle after release; pins float in reset and scan
	assign pixel_data_pins_pulldown = {rscps_pkg::PIN_W{!arst_n ||
		st_ff.state == rscps_pkg::RSCPS_ST_RESET}};
	assign pixel_data_pins_out = '0;
	assign pixel_data_pins_oe  = '0;
	// Memory output enable stays driven high through reset; becomes an input in scan
	assign mem_oe_n_out = 1'b1;
	assign mem_oe_n_oe  = !arst_n || !scan_mode;
	// Serial clock pin becomes the scan output in scan mode
	assign scan_mode                 = (st_ff.state == rscps_pkg::RSCPS_ST_SCAN);
	assign serial_port_clock_pin_out = scan_mode ? st_ff.scan_out : serial_port_clock_func;
	assign serial_port_clock_pin_oe  = (st_ff.state != rscps_pkg::RSCPS_ST_RESET);

	// Field decode of memory configuration
	assign mem_page_mode     = mem_cfg_q[rscps_pkg::PAGE_LSB +: 2];
	assign mem_page_reserved = (mem_page_mode != rscps_pkg::PAGE_EDO1) &&
		(mem_page_mode != rscps_pkg::PAGE_EDO2) && (mem_page_mode != rscps_pkg::PAGE_FPM);
	always_comb begin
		case (mem_cfg_q[rscps_pkg::SIZE_LSB +: 3])
			rscps_pkg::SIZE_4M: mem_size_mb = 3'h4;
			rscps_pkg::SIZE_2M: mem_size_mb = 3'h2;
			rscps_pkg::SIZE_1M: mem_size_mb = 3'h1;
			default:            mem_size_mb = 3'h0;
		endcase
	end
	assign mem_size_reserved = (mem_size_mb == 3'h0);
endmodule

// file: testbench/rscps_sva.sv
// Checker: port-level properties of the strap capture block
// Assumes it is bound to rscps_top and sees only that module's ports
`timescale 1ns/1ps
module rscps_sva (
	input wire logic                        sys_clk,
	input wire logic                        arst_n,
	input wire logic                        psel,
	input wire logic                        penable,
	input wire logic [7:0]                  paddr,
	input wire logic                        pready,
	input wire logic                        pslverr,
	input wire logic [rscps_pkg::PIN_W-1:0] pixel_data_pins_in,
	input wire logic [rscps_pkg::PIN_W-1:0] pixel_data_pins_oe,
	input wire logic [rscps_pkg::PIN_W-1:0] pixel_data_pins_pulldown,
	input wire logic                        mem_oe_n_out,
	input wire logic                        mem_oe_n_oe,
	input wire logic                        serial_port_clock_pin_oe,
	input wire logic                        scan_mode,
	input wire logic [1:0]                  mem_page_mode,
	input wire logic                        mem_page_reserved,
	input wire logic [2:0]                  mem_size_mb,
	input wire logic                        mem_size_reserved
);
	logic [1:0] age_ff;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// Edges since reset release, saturating; the capture edge gives age 1
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			age_ff <= 2'h0;
		else if (age_ff != 2'h3)
			age_ff <= age_ff + 2'h1;
	end
	// Reset-time pin checks must still fire while reset is low
	a_memoe_high: assert property (disable iff (1'b0) !arst_n || !scan_mode |->
		mem_oe_n_out && mem_oe_n_oe) else $error("memory output enable not held inactive");
	a_float_reset: assert property (disable iff (1'b0) !arst_n |->
		pixel_data_pins_oe == '0 && !serial_port_clock_pin_oe) else $error("pin driven in reset");
	a_pull_reset: assert property (disable iff (1'b0) !arst_n |-> &pixel_data_pins_pulldown)
		else $error("pull-down missing in reset");
	a_pull_off: assert property (age_ff[1] |-> pixel_data_pins_pulldown == '0)
		else $error("pull-down active after reset");
	a_scan_entry: assert property (age_ff == 2'h1 |->
		scan_mode == $past(pixel_data_pins_in[rscps_pkg::SCAN_PIN])) else $error("scan entry wrong");
	a_scan_hold: assert property (age_ff == 2'h3 |-> $stable(scan_mode))
		else $error("scan mode changed after capture");
	a_scan_pins: assert property (age_ff[1] && scan_mode |->
		serial_port_clock_pin_oe && !mem_oe_n_oe && pixel_data_pins_oe == '0)
		else $error("scan pin directions");
	a_page_rsvd: assert property (mem_page_reserved == (mem_page_mode == 2'h1))
		else $error("page reserved flag wrong");
	a_size_rsvd: assert property (mem_size_reserved !=
		(mem_size_mb inside {3'h1, 3'h2, 3'h4})) else $error("size reserved flag wrong");
	a_unmapped_err: assert property (psel && penable && paddr > 8'h10 |-> pslverr && pready)
		else $error("unmapped access not refused");
	c_scan: cover property (scan_mode);
	c_err: cover property (pslverr);
	c_rsvd: cover property (mem_page_reserved);
endmodule
bind rscps_top rscps_sva u_rscps_sva (.sys_clk, .arst_n, .psel, .penable, .paddr, .pready,
	.pslverr, .pixel_data_pins_in, .pixel_data_pins_oe, .pixel_data_pins_pulldown,
	.mem_oe_n_out, .mem_oe_n_oe, .serial_port_clock_pin_oe, .scan_mode, .mem_page_mode,
	.mem_page_reserved, .mem_size_mb, .mem_size_reserved);

// file: testbench/rscps_board.sv
// Partner: board strap resistors and the connectivity tester
// Assumes the bench changes pull_up and low_cnt just after clock edges
`timescale 1ns/1ps
module rscps_board (
	input  wire logic [rscps_pkg::PIN_W-1:0]  pull_up,
	input  wire logic                         sys_clk,
	input  wire logic [rscps_pkg::PIN_W-1:0]  pull_dn,
	input  wire logic [6:0]                   low_cnt,
	output logic      [rscps_pkg::PIN_W-1:0]  pins,
	output logic      [rscps_pkg::SCAN_W-1:0] scan_pins
);
	logic [rscps_pkg::PIN_W-1:0]  flt_ff = '0;
	logic [rscps_pkg::SCAN_W-1:0] scan_ff = '1;
	// Undriven pins wander every cycle, so a stale level is never trusted
	always @(posedge sys_clk) flt_ff <= ~flt_ff;
	// A board pull-up wins over the weak internal pull-down
	assign pins = pull_up | (~pull_up & ~pull_dn & flt_ff);
	// Tester: all inputs high, then one more held low per step
	always @(posedge sys_clk) scan_ff <= ~((64'h1 << low_cnt) - 64'h1);
	assign scan_pins = scan_ff;
endmodule

// file: testbench/rscps_tb.sv
// Testbench: strap capture, register access and the pin scan walk
// Assumes rscps_top, the board model and the bound checker
`timescale 1ns/1ps
module rscps_tb;
	logic                        sys_clk = 1'b0;
	logic                        arst_n = 1'b1;
	logic                        psel = 1'b0;
	logic                        penable = 1'b0;
	logic                        pwrite = 1'b0;
	logic [7:0]                  paddr = 8'h00;
	logic [31:0]                 pwdata = 32'h0;
	logic [31:0]                 prdata, r;
	logic                        pready, pslverr, e, scan_mode, serial_port_clock_pin_out;
	logic [rscps_pkg::PIN_W-1:0] pixel_data_pins_in, pixel_data_pins_pulldown, pull_up = '0;
	logic [63:0]                 scan_pins_in;
	logic [6:0]                  low_cnt = 7'h0;
	logic [1:0]                  mem_page_mode;
	logic [2:0]                  mem_size_mb;
	int                          err_total = 0;
	int                          total_checks = 0;
	logic [7:0]                  cfg_v[4] = '{8'h00, 8'h84, 8'hc8, 8'h2c};
	logic [2:0]                  size_x[4] = '{3'h4, 3'h2, 3'h1, 3'h0};
	initial forever #12.5 sys_clk = ~sys_clk;
	rscps_top u_rscps_top (.sys_clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .pixel_data_pins_in, .pixel_data_pins_out(),
		.pixel_data_pins_oe(), .pixel_data_pins_pulldown,
		.mem_oe_n_out(), .mem_oe_n_oe(), .scan_pins_in, .serial_port_clock_pin_out,
		.serial_port_clock_pin_oe(), .serial_port_clock_func(1'b0), .scan_mode,
		.mem_page_mode, .mem_page_reserved(), .mem_size_mb, .mem_size_reserved());
	rscps_board u_rscps_board (.pull_up, .sys_clk, .pull_dn(pixel_data_pins_pulldown),
		.low_cnt, .pins(pixel_data_pins_in), .scan_pins(scan_pins_in));
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
			err_total++;
		end
	endtask
	// One APB transfer; setup waits an edge so no signal is driven twice in a step
	task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge sys_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never sees pready
		do begin
			@(posedge sys_clk);
		end while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(a, 1'b0, 32'h0);
		chk("prdata", r, x);
	endtask
	// Reset with a strap pattern, then read back every captured register
	task automatic strap_reset(input logic [28:0] m);
		logic [28:0] x;
		x = ~m;
		pull_up <= m;
		arst_n <= 1'b0;
		repeat (20) @(posedge sys_clk);
		arst_n <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rdc(8'h00, {24'h0, x[7:0]});
		rdc(8'h04, {24'h0, x[15:8]});
		rdc(8'h08, {24'h0, x[23:16]});
		rdc(8'h0c, {24'h0, 3'h7, x[28:24]});
		rdc(8'h10, {31'h0, m[9]});
		$display("strap capture test done");
	endtask
	task automatic conclude();
		$display("checks %0d mismatches %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	initial begin
		repeat (5000) @(posedge sys_clk);
		err_total++;
		conclude();
	end
	initial begin
		strap_reset(29'h0);
		// Memory config rows: each page code, the three size codes and one reserved size code through the register
		for (int i = 0; i < 4; i++) begin
			apb(8'h00, 1'b1, {24'h0, cfg_v[i]});
			rdc(8'h00, {24'h0, cfg_v[i]});
			chk("page", 32'(mem_page_mode), 32'(cfg_v[i][3:2]));
			chk("size", 32'(mem_size_mb), 32'(size_x[i]));
		end
		$display("register rows test done");
		// Unmapped access is refused and leaves the stored value alone
		apb(8'h14, 1'b1, 32'h5a);
		chk("pslverr", 32'(e), 32'h1);
		rdc(8'h00, 32'h2c);
		apb(8'h00, 1'b1, 32'hffff_ff3c);
		rdc(8'h00, 32'h3c);
		$display("refusal test done");
		// Scan strap, then the tester lowers inputs one by one
		strap_reset(29'h0f0f_a35c);
		chk("scan_mode", 32'(scan_mode), 32'h1);
		for (int n = 1; n < 6; n++) begin
			low_cnt <= 7'(n);
			repeat (3) @(posedge sys_clk);
			chk("scan_out", 32'(serial_port_clock_pin_out), 32'(n % 2));
		end
		$display("scan walk test done");
		conclude();
	end
endmodule
